// File: rtl/msrm_defs.svh
// offsets, field positions, codes and reset values of the sensor register map
`ifndef MSRM_DEFS_SVH
`define MSRM_DEFS_SVH
`define MSRM_REG_COUNT 16'h0020
`define MSRM_MAX_READ 16'h0008
`define MSRM_ADDR_ACK 16'h0000
`define MSRM_ADDR_CMD 16'h0001
`define MSRM_ADDR_PPM 16'h0003
`define MSRM_IN_RSV_TOP 16'h0002
`define MSRM_IN_RSV_MID 16'h0015
`define MSRM_SPACE_INPUT 1'b0
`define MSRM_SPACE_HOLD 1'b1
`define MSRM_BIT_AIR 5
`define MSRM_BIT_ZERO 6
`define MSRM_CMD_CAL 8'h7c
`define MSRM_PAR_AIR 8'h06
`define MSRM_PAR_ZERO 8'h07
`define MSRM_EXC_FUNC 8'h01
`define MSRM_EXC_ADDR 8'h02
`define MSRM_EXC_VALUE 8'h03
`define MSRM_ACK_RESET 16'h0000
`endif

// File: rtl/msrm_pkg.sv
// types of the sensor register map
`default_nettype none
package msrm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } msrm_state_type;

  typedef struct packed {
    msrm_state_type state;
    logic [4:0] cursor;
    logic [3:0] remain;
    logic space;
    logic [15:0] ack;
    logic rsp_valid;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic [15:0] rsp_data;
    logic rsp_last;
    logic air_start;
    logic zero_start;
  } msrm_regs_type;

  localparam msrm_regs_type MSRM_REGS_RESET = '{state: ST_IDLE, default: '0};
endpackage : msrm_pkg
`default_nettype wire

// File: rtl/msrm_decode.sv
// legality decode of one register address in either space
`timescale 1ns/1ps
`default_nettype none
`include "msrm_defs.svh"
module msrm_decode (
  input wire logic space,
  input wire logic [16:0] addr,
  output logic legal
);
  // addresses are zero based: register number minus one [R04]
  always_comb begin
    legal = 1'b0;
    if (addr >= {1'b0, `MSRM_REG_COUNT}) begin
      legal = 1'b0;
    end else if (space == `MSRM_SPACE_INPUT) begin
      // 0..3 and 21 answer; 4..20 and 22..31 raise illegal address [R07] [R02]
      legal = (addr <= {1'b0, `MSRM_ADDR_PPM}) || (addr == {1'b0, `MSRM_IN_RSV_MID});
    end else begin
      // only acknowledge and command live in the holding space [R08] [R07]
      legal = (addr <= {1'b0, `MSRM_ADDR_CMD});
    end
  end
endmodule : msrm_decode
`default_nettype wire

// File: rtl/msrm_regmap.sv
// modbus register map of the gas sensor: input and holding spaces
// Functional notes
// (R01) two independent spaces, input and holding, of 32 sixteen-bit registers
// (R02) reserved locations without exception answer normally and change nothing
// (R03) one input read covers at most eight consecutive addresses
// (R04) link address equals register number minus one
// (R05) input space is read-only, no write path exists
// (R06) input address 3 returns latest gas concentration in ppm
// (R07) input 4-20, 22-31 and holding 2-31 raise illegal data address
// (R08) only holding addresses 0 and 1 are functional
// (R09) acknowledge bit 6 (one-based) sets after air calibration
// (R10) acknowledge bit 7 (one-based) sets after zero calibration
// (R11) command word 7c06 starts air, 7c07 starts zero calibration
// (R12) acknowledge register is read/write, command register write-only
// (R13) command write starts calibration, completion sets matching flag
// (R14) master clears acknowledge, writes command, then polls the flag
// (R15) unknown command words are ignored and leave flags alone
// (R16) illegal address answers exception code 02 with no state change
`timescale 1ns/1ps
`default_nettype none
`include "msrm_defs.svh"
module msrm_regmap
  import msrm_pkg::*;
#(
  parameter int MAX_READ = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_space,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_exc,
  output logic [7:0] rsp_code,
  output logic [15:0] rsp_data,
  output logic rsp_last,
  input wire logic [15:0] gas_ppm,
  output logic cal_air_start,
  output logic cal_zero_start,
  input wire logic cal_air_done,
  input wire logic cal_zero_done
);
  msrm_regs_type r_reg;
  msrm_regs_type r_next;
  logic take;
  logic [15:0] act_cnt;
  logic [MAX_READ-1:0] slot_ok;
  logic range_ok;

  // read value of one address; reserved and write-only locations read zero
  function automatic logic [15:0] read_word(input logic space, input logic [4:0] a,
                                            input logic [15:0] ack, input logic [15:0] ppm);
    read_word = 16'h0000;
    if (space == `MSRM_SPACE_INPUT && a == `MSRM_ADDR_PPM) begin
      read_word = ppm; // [R06]
    end else if (space == `MSRM_SPACE_HOLD && a == `MSRM_ADDR_ACK) begin
      read_word = ack; // [R12]
    end
  endfunction : read_word

  assign take = req_valid && req_ready;
  assign act_cnt = req_write ? 16'h0001 : req_count;

  // every address touched by the request is checked up front [R01] [R07]
  genvar gi;
  generate
    for (gi = 0; gi < MAX_READ; gi++) begin : g_slot
      logic legal;
      msrm_decode u_dec (
        .space(req_space),
        .addr({1'b0, req_addr} + 17'(gi)),
        .legal(legal)
      );
      assign slot_ok[gi] = (16'(gi) >= act_cnt) || legal;
    end
  endgenerate
  assign range_ok = &slot_ok;

  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.rsp_exc = 1'b0;
    r_next.rsp_code = 8'h00;
    r_next.rsp_last = 1'b0;
    r_next.air_start = 1'b0;
    r_next.zero_start = 1'b0;
    case (r_reg.state)
      ST_IDLE: begin
        if (req_valid) begin
          if (req_write) begin
            r_next.rsp_valid = 1'b1;
            r_next.rsp_last = 1'b1;
            r_next.rsp_data = req_wdata;
            if (req_space == `MSRM_SPACE_INPUT) begin
              // no write path into the input space [R05]
              r_next.rsp_exc = 1'b1;
              r_next.rsp_code = `MSRM_EXC_FUNC;
              r_next.rsp_data = 16'h0000;
            end else if (!range_ok) begin
              r_next.rsp_exc = 1'b1; // [R16]
              r_next.rsp_code = `MSRM_EXC_ADDR;
              r_next.rsp_data = 16'h0000;
            end else if (req_addr == `MSRM_ADDR_ACK) begin
              r_next.ack = req_wdata; // [R12]
            end else if (req_wdata[15:8] == `MSRM_CMD_CAL) begin
              // any other parameter falls through untouched [R15]
              r_next.air_start = (req_wdata[7:0] == `MSRM_PAR_AIR); // [R11] [R13]
              r_next.zero_start = (req_wdata[7:0] == `MSRM_PAR_ZERO); // [R11] [R13]
            end
          end else if (req_count == 16'h0000 || req_count > 16'(MAX_READ)) begin
            // quantity is checked before address, as the protocol orders [R03]
            r_next.rsp_valid = 1'b1;
            r_next.rsp_last = 1'b1;
            r_next.rsp_exc = 1'b1;
            r_next.rsp_code = `MSRM_EXC_VALUE;
            r_next.rsp_data = 16'h0000;
          end else if (!range_ok) begin
            r_next.rsp_valid = 1'b1;
            r_next.rsp_last = 1'b1;
            r_next.rsp_exc = 1'b1; // [R16] [R07]
            r_next.rsp_code = `MSRM_EXC_ADDR;
            r_next.rsp_data = 16'h0000;
          end else begin
            r_next.state = ST_READ;
            r_next.cursor = req_addr[4:0];
            r_next.remain = req_count[3:0];
            r_next.space = req_space;
          end
        end
      end
      ST_READ: begin
        // one word per cycle; ppm is sampled as each word is built [R03]
        r_next.rsp_valid = 1'b1;
        r_next.rsp_data = read_word(r_reg.space, r_reg.cursor, r_reg.ack, gas_ppm);
        r_next.rsp_last = (r_reg.remain == 4'h1);
        r_next.cursor = r_reg.cursor + 5'h01;
        r_next.remain = r_reg.remain - 4'h1;
        if (r_reg.remain == 4'h1) begin
          r_next.state = ST_IDLE;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
    // completion sets win over a same-cycle software write [R09] [R10] [R13]
    if (cal_air_done) begin
      r_next.ack[`MSRM_BIT_AIR] = 1'b1;
    end
    if (cal_zero_done) begin
      r_next.ack[`MSRM_BIT_ZERO] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= MSRM_REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ready is combinational so a new request may follow a write answer at once
  assign req_ready = (r_reg.state == ST_IDLE);
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_exc = r_reg.rsp_exc;
  assign rsp_code = r_reg.rsp_code;
  assign rsp_data = r_reg.rsp_data;
  assign rsp_last = r_reg.rsp_last;
  assign cal_air_start = r_reg.air_start;
  assign cal_zero_start = r_reg.zero_start;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic no_done;
  assign no_done = !cal_air_done && !cal_zero_done;

  exc_range_a: assert property (take && !req_write && req_space == `MSRM_SPACE_INPUT // [R07]
      && req_addr == 16'h0005 && req_count == 16'h0001
      |=> rsp_valid && rsp_exc && rsp_code == 8'h02)
    else $error("illegal input address not refused");
  reserved_ok_a: assert property (take && !req_write && req_space == `MSRM_SPACE_INPUT // [R02]
      && req_addr == 16'h0000 && req_count == 16'h0001
      |=> !rsp_valid ##1 rsp_valid && !rsp_exc && rsp_data == 16'h0000 && rsp_last)
    else $error("reserved input read misanswered");
  ppm_read_a: assert property (take && !req_write && req_space == `MSRM_SPACE_INPUT // [R06]
      && req_addr == 16'h0003 && req_count == 16'h0001
      |=> ##1 rsp_valid && rsp_data == $past(gas_ppm))
    else $error("concentration read wrong");
  count_cap_a: assert property (take && !req_write && req_count > 16'h0008 // [R03]
      |=> rsp_valid && rsp_exc && rsp_last && req_ready)
    else $error("oversize read accepted");
  no_input_wr_a: assert property (take && req_write && req_space == `MSRM_SPACE_INPUT // [R05]
      && no_done |=> rsp_exc && $stable(r_reg.ack) && !cal_air_start && !cal_zero_start)
    else $error("input space write had effect");
  air_cmd_a: assert property (take && req_write && req_space == `MSRM_SPACE_HOLD // [R11]
      && req_addr == 16'h0001 && req_wdata == 16'h7c06
      |=> cal_air_start && !cal_zero_start && !rsp_exc ##1 !cal_air_start)
    else $error("air command not started");
  zero_cmd_a: assert property (take && req_write && req_space == `MSRM_SPACE_HOLD // [R13]
      && req_addr == 16'h0001 && req_wdata == 16'h7c07 |=> cal_zero_start && !cal_air_start)
    else $error("zero command not started");
  bad_cmd_a: assert property (take && req_write && req_space == `MSRM_SPACE_HOLD // [R15]
      && req_addr == 16'h0001 && req_wdata != 16'h7c06 && req_wdata != 16'h7c07 && no_done
      |=> !cal_air_start && !cal_zero_start && $stable(r_reg.ack))
    else $error("unknown command acted");
  // one cycle only: the master may legally clear the flag right after it sets
  air_flag_a: assert property (cal_air_done |=> r_reg.ack[5]) // [R09]
    else $error("air flag not set");
  zero_flag_a: assert property (cal_zero_done |=> r_reg.ack[6]) // [R10]
    else $error("zero flag not set");
  ack_rw_a: assert property (take && req_write && req_space == `MSRM_SPACE_HOLD // [R12]
      && req_addr == 16'h0000 && no_done |=> r_reg.ack == $past(req_wdata) && !rsp_exc)
    else $error("acknowledge write lost");
  exc_still_a: assert property (rsp_valid && rsp_exc && !$past(cal_air_done) // [R16]
      && !$past(cal_zero_done) |-> $stable(r_reg.ack) && !cal_air_start && !cal_zero_start)
    else $error("exception changed state");

  cover_ppm_c: cover property (take && !req_write && req_addr == 16'h0003);
  cover_burst_c: cover property (rsp_valid && !rsp_exc && !rsp_last ##1 rsp_valid [*3]);
  cover_cal_c: cover property (cal_air_start ##[1:20] cal_air_done);
  cover_exc_c: cover property (rsp_valid && rsp_code == 8'h02);
endmodule : msrm_regmap
`default_nettype wire

// File: test/msrm_cal_model.sv
// calibration engine model: answers each start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module msrm_cal_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic cal_air_start,
  input wire logic cal_zero_start,
  output var logic cal_air_done = 1'b0,
  output var logic cal_zero_done = 1'b0
);
  int cnt = 0;
  logic zero_sel = 1'b0;
  // slow mode keeps the flag low long enough to be seen clear when polled
  always @(posedge clk_sys) begin
    cal_air_done <= 1'b0;
    cal_zero_done <= 1'b0;
    if (!rst_n) cnt <= 0;
    else if (cal_air_start || cal_zero_start) begin
      cnt <= slow ? 40 : 3;
      zero_sel <= cal_zero_start;
    end else if (cnt == 1) begin
      cal_air_done <= !zero_sel;
      cal_zero_done <= zero_sel;
      cnt <= 0;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : msrm_cal_model
`default_nettype wire

// File: test/tb_modbus_sensor_register_map.sv
// self-checking bench of the sensor register map
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_sensor_register_map;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_space = 1'b0, slow = 1'b0;
  logic [15:0] req_addr = '0, req_count = '0, req_wdata = '0, gas_ppm = '0;
  logic req_ready, rsp_valid, rsp_exc, rsp_last;
  logic cal_air_start, cal_zero_start, cal_air_done, cal_zero_done;
  logic [7:0] rsp_code;
  logic [15:0] rsp_data;
  logic [15:0] exp_ack = 16'h0000;
  int err_count = 0, n_tests = 0, n_air = 0, n_zero = 0, w;
  initial forever #12.5 clk_sys = ~clk_sys;
  msrm_regmap #(.MAX_READ(8)) u_dut (.clk_sys, .rst_n, .req_valid, .req_ready,
    .req_write, .req_space, .req_addr, .req_count, .req_wdata, .rsp_valid,
    .rsp_exc, .rsp_code, .rsp_data, .rsp_last, .gas_ppm, .cal_air_start,
    .cal_zero_start, .cal_air_done, .cal_zero_done);
  msrm_cal_model u_cal (.clk_sys, .rst_n, .slow, .cal_air_start,
    .cal_zero_start, .cal_air_done, .cal_zero_done);
  always @(posedge clk_sys) begin
    if (cal_air_done === 1'b1) exp_ack[5] = 1'b1;
    if (cal_zero_done === 1'b1) exp_ack[6] = 1'b1;
    if (cal_air_start === 1'b1) n_air++;
    if (cal_zero_start === 1'b1) n_zero++;
  end
  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic bit legal(input bit sp, input int a);
    return sp ? a <= 1 : (a <= 3 || a == 21);
  endfunction : legal
  // one request in, every answer word compared against the model
  task automatic req(input bit wr, input bit sp, input int a, input int n,
                     input logic [15:0] wd);
    logic [7:0] exc;
    logic [15:0] q[$];
    gas_ppm = 16'($urandom);
    exc = 8'h00;
    if (wr && !sp) exc = 8'h01;
    else if (!wr && (n == 0 || n > 8)) exc = 8'h03;
    else for (int i = 0; i < (wr ? 1 : n); i++) if (!legal(sp, a + i)) exc = 8'h02;
    if (exc != 8'h00) q.push_back(16'h0000);
    else if (wr) begin
      q.push_back(wd);
      if (sp && a == 0) exp_ack = wd;
    end else for (int i = 0; i < n; i++)
      q.push_back((!sp && a + i == 3) ? gas_ppm : (sp && a + i == 0) ? exp_ack : 16'h0000);
    req_write = wr;
    req_space = sp;
    req_addr = a[15:0];
    req_count = n[15:0];
    req_wdata = wd;
    req_valid = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    // ready drops only while a good read streams its words
    check(26'(req_ready), 26'(exc != 8'h00 || wr));
    for (int k = 0; k < 12 && q.size() > 0; k++) begin
      if (rsp_valid === 1'b1) begin
        check({rsp_exc, rsp_code, rsp_data, rsp_last},
              {exc != 8'h00, exc, q[0], q.size() == 1});
        void'(q.pop_front());
      end
      if (q.size() > 0) @(negedge clk_sys);
    end
    check(26'(q.size()), 26'h0);
    @(negedge clk_sys);
  endtask : req
  task automatic test_end(input string s);
    $display("test %s ends", s);
  endtask : test_end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #1ms;
    err_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h37fc4ae6));
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    req(0, 1, 0, 1, 16'h0000);
    req(0, 0, 0, 4, 16'h0000);
    req(0, 0, 21, 1, 16'h0000);
    test_end("reset and input reads");
    for (int a = 0; a < 33; a++) begin
      req(0, 0, a, 1, 16'h0000);
      req(0, 1, a, 1, 16'h0000);
    end
    test_end("address decode");
    req(0, 0, 0, 8, 16'h0000);
    req(0, 0, 0, 0, 16'h0000);
    req(0, 0, 0, 9, 16'h0000);
    req(0, 1, 0, 2, 16'h0000);
    req(0, 0, 20, 3, 16'h0000);
    req(1, 0, 3, 1, 16'h1234);
    req(1, 1, 0, 1, 16'h00a5);
    req(1, 1, 7, 1, 16'hffff);
    req(0, 1, 0, 1, 16'h0000);
    test_end("counts and refusals");
    for (int z = 0; z < 2; z++) begin
      slow = z[0];
      req(1, 1, 0, 1, 16'h0000);
      req(1, 1, 1, 1, {8'h7c, z ? 8'h07 : 8'h06});
      // first poll lands before the engine finishes, so the flag must read clear
      req(0, 1, 0, 1, 16'h0000);
      for (w = 0; w < 60 && !exp_ack[5 + z]; w++) @(negedge clk_sys);
      req(0, 1, 0, 1, 16'h0000);
    end
    check(26'({n_air[7:0], n_zero[7:0]}), 26'h0101);
    req(1, 1, 1, 1, 16'h7c05);
    req(1, 1, 1, 1, 16'h7d06);
    req(1, 1, 1, 1, 16'h7c08);
    repeat (50) @(negedge clk_sys);
    req(0, 1, 0, 1, 16'h0000);
    check(26'({n_air[7:0], n_zero[7:0]}), 26'h0101);
    test_end("calibration");
    // mid-run reset must drop the flags set above and leave the bus idle
    rst_n = 1'b0;
    exp_ack = 16'h0000;
    repeat (5) @(negedge clk_sys);
    check(26'({req_ready, rsp_valid, cal_air_start, cal_zero_start}), 26'h8);
    rst_n = 1'b1;
    @(negedge clk_sys);
    req(0, 1, 0, 1, 16'h0000);
    test_end("mid-run reset");
    // upper byte kept clear so random writes never start a calibration
    repeat (40) req(1'($urandom), 1'($urandom), $urandom_range(0, 40),
                    $urandom_range(0, 10), {8'h00, 8'($urandom)});
    test_end("random traffic");
    tally_and_finish();
  end
endmodule : tb_modbus_sensor_register_map
`default_nettype wire
